// file: hw/itw_pkg.sv
// Package for the interval timer and watchdog block
package itw_pkg;
    // Register word offsets on the Avalon-MM bus (byte addresses)
    localparam logic [7:0] ITW_OFS_COUNT_CTRL = 8'hec;
    localparam logic [7:0] ITW_OFS_WDT_DATA   = 8'hf0;
    localparam logic [7:0] ITW_OFS_IRQ_STAT   = 8'hf4;
    localparam logic [7:0] ITW_OFS_IRQ_MASK   = 8'hf8;
    localparam logic [7:0] ITW_OFS_MODE       = 8'hfc;
    // Control register fields, and the clear bit of the watchdog data register
    localparam int ITW_SEL_LSB   = 0;
    localparam int ITW_CLR_BIT   = 3;
    localparam int ITW_WATCHDOG_RESET_ENABLE_BIT = 4;
    localparam int ITW_RCSEL_BIT = 5;
    localparam int ITW_WCLR_BIT  = 7;
    // Status bit positions
    localparam int ITW_ST_OVF = 0;
    localparam int ITW_ST_WDT = 1;
    // Reset values
    localparam logic [7:0] ITW_CTRL_RST = 8'h00;
    localparam logic [7:0] ITW_WDT_RST  = 8'h7f;
    // Smallest prescale is divide by 8; largest divide by 1024
    localparam int ITW_PRE_W = 10;
    // Reset pulse length driven out on a watchdog reset
    localparam int ITW_RST_PULSE = 4;

    typedef enum logic [1:0] {ITW_RUN, ITW_STOP_MAIN, ITW_STOP_RC} itw_mode_t;

    typedef struct packed {
        logic       rc_watchdog_select;
        logic       watchdog_reset_enable;
        logic [2:0] clock_select;
    } itw_ctrl_t;
endpackage : itw_pkg

// file: hw/itw_top.sv
// Interval counter and watchdog with Avalon-MM register slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
module itw_top
    import itw_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        rc_tick,
    input  wire logic        stop_req,
    input  wire logic        stop_release,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    output logic             irq,
    output logic             wdt_reset_n
);
    itw_ctrl_t          ctrl_reg;
    logic      [7:0]    count_reg;
    logic      [6:0]    wdt_cnt_reg;
    logic      [6:0]    wdt_cmp_reg;
    logic               wclr_reg;
    logic               bclr_reg;
    logic               armed_reg;
    logic [ITW_PRE_W-1:0] pre_reg;
    itw_mode_t          mode_reg;
    logic      [1:0]    stat_reg;
    logic      [1:0]    mask_reg;
    logic      [2:0]    rst_cnt_reg;
    logic               ack_reg;
    logic      [31:0]   rdata_reg;
    logic      [1:0]    resp_reg;
    logic               tick;
    logic               ovf;
    logic               match;
    logic               main_run;
    logic               wr_ev;
    logic               rd_ev;
    logic               wr_ctrl;
    logic               wr_wdt;
    logic               hit;
    logic [ITW_PRE_W-1:0] pre_mask;
    logic               stat_clr;

    // Bus: one wait cycle, answer on the second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_ev   = avs_write & ack_reg;
    assign rd_ev   = avs_read & ack_reg;
    assign wr_ctrl = wr_ev & avs_byteenable[0] & (avs_address == ITW_OFS_COUNT_CTRL);
    assign wr_wdt  = wr_ev & avs_byteenable[0] & (avs_address == ITW_OFS_WDT_DATA);
    assign hit = (avs_address == ITW_OFS_COUNT_CTRL) | (avs_address == ITW_OFS_WDT_DATA)
               | (avs_address == ITW_OFS_IRQ_STAT) | (avs_address == ITW_OFS_IRQ_MASK)
               | (avs_address == ITW_OFS_MODE);
    assign avs_readdata = rdata_reg;
    assign avs_response = resp_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= 2'b00;
        end
        else if ((avs_read | avs_write) & ~ack_reg)
        begin
            resp_reg  <= hit ? 2'b00 : 2'b10;
            rdata_reg <= 32'h0000_0000;
            if (avs_read)
            begin
                case (avs_address)
                    ITW_OFS_COUNT_CTRL: rdata_reg <= {24'h000000, count_reg};
                    ITW_OFS_WDT_DATA:   rdata_reg <= {24'h000000, wclr_reg, wdt_cmp_reg};
                    ITW_OFS_IRQ_STAT:   rdata_reg <= {30'h0, stat_reg};
                    ITW_OFS_IRQ_MASK:   rdata_reg <= {30'h0, mask_reg};
                    ITW_OFS_MODE:       rdata_reg <= {30'h0, mode_reg};
                    default:            rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control register, write only through the shared address
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_reg <= itw_ctrl_t'(ITW_CTRL_RST[4:0]);
        else if (wr_ctrl)
        begin
            ctrl_reg.clock_select          <= avs_writedata[ITW_SEL_LSB +: 3];
            ctrl_reg.watchdog_reset_enable <= avs_writedata[ITW_WATCHDOG_RESET_ENABLE_BIT];
            ctrl_reg.rc_watchdog_select    <= avs_writedata[ITW_RCSEL_BIT];
        end
    end

    // Self-clearing interval-clear bit
    always_ff @(posedge mclk)
    begin
        if (rst)
            bclr_reg <= 1'b0;
        else
            bclr_reg <= wr_ctrl & avs_writedata[ITW_CLR_BIT];
    end

    // Low-power mode
    always_ff @(posedge mclk)
    begin
        if (rst)
            mode_reg <= ITW_RUN;
        else
        begin
            case (mode_reg)
                ITW_RUN:
                    if (stop_req)
                        mode_reg <= ctrl_reg.rc_watchdog_select ? ITW_STOP_RC : ITW_STOP_MAIN;
                ITW_STOP_MAIN, ITW_STOP_RC:
                    if (stop_release)
                        mode_reg <= ITW_RUN;
                default:
                    mode_reg <= ITW_RUN;
            endcase
        end
    end

    // Prescaler and count tick select
    assign main_run = (mode_reg != ITW_STOP_MAIN);
    assign pre_mask = ITW_PRE_W'((11'd8 << ctrl_reg.clock_select) - 11'd1);
    assign tick = ctrl_reg.rc_watchdog_select ? rc_tick
                : (main_run & ((pre_reg & pre_mask) == pre_mask));

    always_ff @(posedge mclk)
    begin
        if (rst)
            pre_reg <= '0;
        else if (main_run)
            pre_reg <= pre_reg + 1'b1;
    end

    // Interval counter, free running
    assign ovf = tick & (count_reg == 8'hff) & ~bclr_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
            count_reg <= 8'h00;
        else if (bclr_reg)
            count_reg <= 8'h00;
        else if (tick)
            count_reg <= count_reg + 8'h01;
    end

    // Watchdog counter armed by the first interval clear
    always_ff @(posedge mclk)
    begin
        if (rst)
            armed_reg <= 1'b0;
        else if (bclr_reg)
            armed_reg <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wdt_cmp_reg <= ITW_WDT_RST[6:0];
            wclr_reg    <= 1'b0;
        end
        else
        begin
            if (wr_wdt)
                wdt_cmp_reg <= avs_writedata[6:0];
            wclr_reg <= wr_wdt & avs_writedata[ITW_WCLR_BIT];
        end
    end

    assign match = (wdt_cnt_reg == wdt_cmp_reg) & ovf & armed_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
            wdt_cnt_reg <= 7'h00;
        else if (wclr_reg)
            wdt_cnt_reg <= 7'h00;
        else if (match)
            wdt_cnt_reg <= 7'h00;
        else if (ovf & armed_reg)
            wdt_cnt_reg <= wdt_cnt_reg + 7'h01;
    end

    // Reset pulse on match with enable set
    always_ff @(posedge mclk)
    begin
        if (rst)
            rst_cnt_reg <= 3'd0;
        else if (match & ctrl_reg.watchdog_reset_enable)
            rst_cnt_reg <= 3'(ITW_RST_PULSE);
        else if (rst_cnt_reg != 3'd0)
            rst_cnt_reg <= rst_cnt_reg - 3'd1;
    end
    assign wdt_reset_n = (rst_cnt_reg == 3'd0);

    // Sticky status, read clears only the bits returned, set wins
    assign stat_clr = rd_ev & (avs_address == ITW_OFS_IRQ_STAT);

    always_ff @(posedge mclk)
    begin
        if (rst)
            stat_reg <= 2'b00;
        else
        begin
            stat_reg[ITW_ST_OVF] <= ovf
                | (stat_reg[ITW_ST_OVF] & ~(stat_clr & rdata_reg[ITW_ST_OVF]));
            stat_reg[ITW_ST_WDT] <= (match & ~ctrl_reg.watchdog_reset_enable)
                | (stat_reg[ITW_ST_WDT] & ~(stat_clr & rdata_reg[ITW_ST_WDT]));
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            mask_reg <= 2'b00;
        else if (wr_ev & avs_byteenable[0] & (avs_address == ITW_OFS_IRQ_MASK))
            mask_reg <= avs_writedata[1:0];
    end
    assign irq = |(stat_reg & mask_reg);

    AST_BCLR_ONE: assert property (@(posedge mclk) disable iff (rst)
        bclr_reg |=> !bclr_reg)
        else $error("interval clear not one cycle");

    AST_CLR_ZERO: assert property (@(posedge mclk) disable iff (rst)
        bclr_reg |=> count_reg == 8'h00)
        else $error("count not cleared");

    AST_OVF_FLAG: assert property (@(posedge mclk) disable iff (rst)
        ovf |=> stat_reg[ITW_ST_OVF])
        else $error("overflow flag missing");

    AST_WCLR: assert property (@(posedge mclk) disable iff (rst)
        wclr_reg |=> wdt_cnt_reg == 7'h00 && !wclr_reg)
        else $error("wdt clear failed");

    AST_RSTOUT: assert property (@(posedge mclk) disable iff (rst)
        match && ctrl_reg.watchdog_reset_enable |=> !wdt_reset_n[*4] ##1 wdt_reset_n)
        else $error("reset pulse wrong");

    AST_WATCHDOG_INTERRUPT_FLAG: assert property (@(posedge mclk) disable iff (rst)
        match && !ctrl_reg.watchdog_reset_enable |=> stat_reg[ITW_ST_WDT])
        else $error("wdt flag missing");

    AST_FREEZE: assert property (@(posedge mclk) disable iff (rst)
        mode_reg == ITW_STOP_MAIN && !ctrl_reg.rc_watchdog_select && !bclr_reg
        |=> $stable(count_reg))
        else $error("counter moved in stop");

    AST_ARM: assert property (@(posedge mclk) disable iff (rst)
        !armed_reg && !wclr_reg |=> $stable(wdt_cnt_reg))
        else $error("wdt ran unarmed");

    AST_RCMODE: assert property (@(posedge mclk) disable iff (rst)
        mode_reg == ITW_RUN && stop_req && ctrl_reg.rc_watchdog_select
        |=> mode_reg == ITW_STOP_RC)
        else $error("rc mode not entered");

    AST_MAINSTOP: assert property (@(posedge mclk) disable iff (rst)
        mode_reg == ITW_RUN && stop_req && !ctrl_reg.rc_watchdog_select
        |=> mode_reg == ITW_STOP_MAIN)
        else $error("main stop not entered");

    AST_RESUME: assert property (@(posedge mclk) disable iff (rst)
        mode_reg != ITW_RUN && stop_release
        |=> mode_reg == ITW_RUN)
        else $error("stop not released");

    AST_WAIT_ONE: assert property (@(posedge mclk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus answer late");

    AST_IDLE_BUS: assert property (@(posedge mclk) disable iff (rst)
        !avs_read && !avs_write
        |-> !avs_waitrequest)
        else $error("wait while idle");

    AST_CNT_STEP: assert property (@(posedge mclk) disable iff (rst)
        tick && !bclr_reg
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not step");

    AST_CNT_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !tick && !bclr_reg
        |=> $stable(count_reg))
        else $error("count moved without tick");

    AST_OVF_WRAP: assert property (@(posedge mclk) disable iff (rst)
        ovf
        |=> count_reg == 8'h00)
        else $error("overflow did not wrap");

    AST_RC_SRC: assert property (@(posedge mclk) disable iff (rst)
        ctrl_reg.rc_watchdog_select
        |-> tick == rc_tick)
        else $error("rc source not used");

    AST_BCLR_SET: assert property (@(posedge mclk) disable iff (rst)
        wr_ctrl && avs_writedata[ITW_CLR_BIT]
        |=> bclr_reg)
        else $error("interval clear not taken");

    AST_SEL_WR: assert property (@(posedge mclk) disable iff (rst)
        wr_ctrl
        |=> ctrl_reg.clock_select == $past(avs_writedata[2:0]))
        else $error("select not written");

    AST_EN_WR: assert property (@(posedge mclk) disable iff (rst)
        wr_ctrl
        |=> ctrl_reg.watchdog_reset_enable == $past(avs_writedata[ITW_WATCHDOG_RESET_ENABLE_BIT]))
        else $error("enable not written");

    AST_RCSEL_WR: assert property (@(posedge mclk) disable iff (rst)
        wr_ctrl
        |=> ctrl_reg.rc_watchdog_select == $past(avs_writedata[ITW_RCSEL_BIT]))
        else $error("rc select not written");

    AST_WDT_STEP: assert property (@(posedge mclk) disable iff (rst)
        ovf && armed_reg && !match && !wclr_reg
        |=> wdt_cnt_reg == $past(wdt_cnt_reg) + 7'h01)
        else $error("wdt did not step");

    AST_WDT_HOLD: assert property (@(posedge mclk) disable iff (rst)
        !ovf && !wclr_reg
        |=> $stable(wdt_cnt_reg))
        else $error("wdt moved without overflow");

    AST_MATCH_ZERO: assert property (@(posedge mclk) disable iff (rst)
        match && !wclr_reg
        |=> wdt_cnt_reg == 7'h00)
        else $error("wdt not zeroed on match");

    AST_WCLR_SET: assert property (@(posedge mclk) disable iff (rst)
        wr_wdt && avs_writedata[ITW_WCLR_BIT]
        |=> wclr_reg)
        else $error("wdt clear not taken");

    AST_NO_FLAG_EN: assert property (@(posedge mclk) disable iff (rst)
        match && ctrl_reg.watchdog_reset_enable && !stat_reg[ITW_ST_WDT]
        |=> !stat_reg[ITW_ST_WDT])
        else $error("wdt flag set in reset mode");

    AST_NO_RST_DIS: assert property (@(posedge mclk) disable iff (rst)
        !ctrl_reg.watchdog_reset_enable && wdt_reset_n
        |=> wdt_reset_n)
        else $error("reset while disabled");
endmodule : itw_top

// file: sim/itw_tb.sv
// Self-checking testbench for the interval timer and watchdog block
`timescale 1ns/10ps
module tb;
    import itw_pkg::*;
    logic        mclk           = 1'b0;
    logic        rst            = 1'b1;
    logic        rc_tick        = 1'b0;
    logic        stop_req       = 1'b0;
    logic        stop_release   = 1'b0;
    logic [7:0]  avs_address    = 8'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        irq;
    logic        wdt_reset_n;
    logic        rc_on          = 1'b0;
    logic [1:0]  rc_div         = 2'h0;
    logic [31:0] rd;
    logic [31:0] cnt_a;
    logic [1:0]  rsp;
    int          err_total      = 0;
    int          num_checks     = 0;
    int          low_n          = 0;

    itw_top DUT (.mclk(mclk), .rst(rst), .rc_tick(rc_tick), .stop_req(stop_req),
        .stop_release(stop_release), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .irq(irq),
        .wdt_reset_n(wdt_reset_n));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // RC tick every fourth cycle while enabled, low reset pulse length
    always @(posedge mclk)
    begin
        rc_div <= rc_div + 2'h1;
        rc_tick <= rc_on && (rc_div == 2'h0);
        if (wdt_reset_n === 1'b0)
            low_n <= low_n + 1;
    end

    task automatic stop_test;
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        avs_address <= addr;
        avs_writedata <= data;
        avs_read <= !wr;
        avs_write <= wr;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        rsp = avs_response;
        check("bus answer", 32'(n < 50), 32'h1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        check(what, rd, exp);
    endtask : rdchk

    task automatic rdrng(input string what, input int lo, input int hi);
        bus(1'b0, ITW_OFS_COUNT_CTRL, 32'h0);
        check(what, 32'(rd >= lo && rd <= hi), 32'h1);
    endtask : rdrng

    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("reset out", 32'(wdt_reset_n), 32'h1);
        check("irq idle", 32'(irq), 32'h0);
        rdchk("compare reset", ITW_OFS_WDT_DATA, 32'h7f);
        rdchk("status reset", ITW_OFS_IRQ_STAT, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped resp", 32'(rsp), 32'h2);
        check("unmapped data", rd, 32'h0);
        for (int s = 0; s < 8; s++)
        begin
            bus(1'b1, ITW_OFS_COUNT_CTRL, 32'(s) | 32'h08);
            rdrng("count cleared", 0, 1);
            repeat ((8 << s) * 4) @(posedge mclk);
            rdrng("count rate", 3, 6);
        end
        bus(1'b1, ITW_OFS_IRQ_MASK, 32'h1);
        bus(1'b1, ITW_OFS_COUNT_CTRL, 32'h08);
        bus(1'b0, ITW_OFS_IRQ_STAT, 32'h0);
        repeat (1900) @(posedge mclk);
        check("irq early", 32'(irq), 32'h0);
        repeat (300) @(posedge mclk);
        check("irq overflow", 32'(irq), 32'h1);
        rdchk("status overflow", ITW_OFS_IRQ_STAT, 32'h1);
        rdchk("status cleared", ITW_OFS_IRQ_STAT, 32'h0);
        check("irq cleared", 32'(irq), 32'h0);
        bus(1'b1, ITW_OFS_IRQ_MASK, 32'h2);
        bus(1'b1, ITW_OFS_WDT_DATA, 32'h82);
        rdchk("clear bit drops", ITW_OFS_WDT_DATA, 32'h02);
        bus(1'b1, ITW_OFS_COUNT_CTRL, 32'h08);
        repeat (3990) @(posedge mclk);
        bus(1'b0, ITW_OFS_IRQ_STAT, 32'h0);
        check("wdt flag early", 32'(rd[ITW_ST_WDT]), 32'h0);
        repeat (2400) @(posedge mclk);
        check("wdt irq", 32'(irq), 32'h1);
        bus(1'b0, ITW_OFS_IRQ_STAT, 32'h0);
        check("wdt flag", 32'(rd[ITW_ST_WDT]), 32'h1);
        check("no reset", 32'(low_n), 32'h0);
        bus(1'b1, ITW_OFS_COUNT_CTRL, 32'h28);
        repeat (200) @(posedge mclk);
        rdrng("rc source idle", 0, 0);
        rc_on <= 1'b1;
        repeat (400) @(posedge mclk);
        rc_on <= 1'b0;
        rdrng("rc source ticks", 98, 102);
        for (int r = 0; r < 2; r++)
        begin
            bus(1'b1, ITW_OFS_COUNT_CTRL, (r == 1) ? 32'h28 : 32'h08);
            stop_req <= 1'b1;
            @(posedge mclk);
            stop_req <= 1'b0;
            rdchk("stop mode", ITW_OFS_MODE, 32'(r + 1));
            bus(1'b0, ITW_OFS_COUNT_CTRL, 32'h0);
            cnt_a = rd;
            repeat (400) @(posedge mclk);
            rdchk("count frozen", ITW_OFS_COUNT_CTRL, cnt_a);
            stop_release <= 1'b1;
            @(posedge mclk);
            stop_release <= 1'b0;
            rdchk("run mode", ITW_OFS_MODE, 32'h0);
        end
        bus(1'b1, ITW_OFS_WDT_DATA, 32'h81);
        bus(1'b1, ITW_OFS_COUNT_CTRL, 32'h18);
        for (int k = 0; k < 5; k++)
        begin
            repeat (1500) @(posedge mclk);
            bus(1'b1, ITW_OFS_WDT_DATA, 32'h81);
        end
        check("serviced no reset", 32'(low_n), 32'h0);
        repeat (5000) @(posedge mclk);
        check("reset pulse", 32'(low_n), 32'(ITW_RST_PULSE));
        stop_test();
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        err_total++;
        stop_test();
    end
endmodule : tb
